// ==== include/tadc_pkg.sv ====
// Shared constants for the touch converter serial link
package tadc_pkg;
	localparam int          TADC_RES_BITS   = 12;            // Result width
	localparam int          TADC_CTRL_BITS  = 8;             // Control word incl. start bit
	localparam int          TADC_ACQ_EDGE   = 5;             // Falling edge opening acquisition
	localparam int          TADC_ACQ_CYC    = 3;             // Acquisition cycles
	localparam int          TADC_CONV_CLKS  = 24;            // Clocks per conversion frame
	localparam int          TADC_LSB_DIV    = 4096;          // Code steps over reference
	localparam logic [11:0] TADC_RES_RST    = 12'h000;       // Result reset value
	localparam logic [7:0]  TADC_CTRL_RST   = 8'h00;         // Control reset value
	localparam int          TADC_CLK_DIV    = 4;             // Half period of link clock, clk cycles
	localparam int          TADC_FIFO_DEPTH = 32;            // Host result FIFO depth
	localparam int          TADC_FIFO_W     = 20;            // Control byte plus result
endpackage : tadc_pkg

// ==== include/tadc_if.sv ====
// Pin-level interface between host and touch converter
`timescale 1ns/100ps
interface tadc_if;
	logic cs_b;                     // Chip select, active low
	logic serial_conversion_clock;  // Host-made serial clock
	logic din;                      // Control input
	logic dout_o;                   // Result output value
	logic dout_oe;                  // Result output enable
	logic busy_o;                   // Busy value
	logic busy_oe;                  // Busy enable
	logic pen_touch_irq_oe;         // Open-drain pull-down enable
	wire  dout_w = dout_oe ? dout_o : 1'b0;
	wire  busy_w = busy_oe ? busy_o : 1'b0;
	wire  pen_touch_irq_w = ~pen_touch_irq_oe; // External pull-up
	modport dev (input cs_b, serial_conversion_clock, din,
		output dout_o, dout_oe, busy_o, busy_oe, pen_touch_irq_oe);
	modport host (output cs_b, serial_conversion_clock, din,
		input dout_w, busy_w, pen_touch_irq_w);
endinterface : tadc_if

// ==== design/tadc_fifo.sv ====
// Parameterised valid/ready FIFO
`timescale 1ns/100ps
module tadc_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Handshakes
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop)  rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : tadc_fifo

// ==== design/tadc_dev.sv ====
// Converter end of the serial link
`timescale 1ns/100ps
module tadc_dev
	import tadc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	tadc_if.dev              link,
	input  wire logic [11:0] sample_code,
	input  wire logic        pen_down,
	output logic             acq_active,
	output logic [7:0]       ctrl_word
);
	typedef enum logic [1:0] {
		TADC_IDLE = 2'b00,
		TADC_CMD  = 2'b01,
		TADC_CONV = 2'b10,
		TADC_OUT  = 2'b11
	} tadc_st_t;

	logic [2:0]  cs_sync_q;
	logic [2:0]  sck_sync_q;
	logic [1:0]  din_sync_q;
	logic [1:0]  pen_sync_q;
	logic        sel;
	logic        rise;
	logic        fall;
	tadc_st_t    st_q;
	logic [4:0]  bit_q;
	logic [4:0]  fall_q;
	logic [6:0]  cmd_q;
	logic [11:0] res_q;
	logic [11:0] code_q;

	///////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, edges from stages two and three
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_sync_q  <= 3'h7;
			sck_sync_q <= 3'h0;
			din_sync_q <= 2'h0;
			pen_sync_q <= 2'h0;
		end else begin
			cs_sync_q  <= {cs_sync_q[1:0], link.cs_b};
			sck_sync_q <= {sck_sync_q[1:0], link.serial_conversion_clock};
			din_sync_q <= {din_sync_q[0], link.din};
			pen_sync_q <= {pen_sync_q[0], pen_down};
		end
	end
	assign sel  = ~cs_sync_q[1];
	assign rise = sck_sync_q[1] & ~sck_sync_q[2];
	assign fall = ~sck_sync_q[1] & sck_sync_q[2];

	///////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q   <= TADC_IDLE;
			bit_q  <= 5'h00;
			fall_q <= 5'h00;
			cmd_q  <= 7'h00;
		end else if (!sel) begin
			st_q   <= TADC_IDLE;
			bit_q  <= 5'h00;
			fall_q <= 5'h00;
		end else begin
			unique case (st_q)
				TADC_IDLE: begin
					if (rise && din_sync_q[1]) begin
						st_q   <= TADC_CMD;
						bit_q  <= 5'h01;
						fall_q <= 5'h00;
					end
				end
				TADC_CMD: begin
					if (rise) begin
						cmd_q <= {cmd_q[5:0], din_sync_q[1]};
						bit_q <= bit_q + 5'h01;
					end
					if (fall) fall_q <= fall_q + 5'h01;
					if (rise && bit_q == 5'(TADC_CTRL_BITS - 1)) st_q <= TADC_CONV;
				end
				TADC_CONV: begin
					if (fall) begin
						fall_q <= fall_q + 5'h01;
						if (fall_q == 5'(TADC_CTRL_BITS)) begin
							st_q  <= TADC_OUT;
							bit_q <= 5'h00;
						end
					end
				end
				TADC_OUT: begin
					if (fall) begin
						bit_q <= bit_q + 5'h01;
						if (bit_q == 5'(TADC_CONV_CLKS - TADC_CTRL_BITS)) st_q <= TADC_IDLE;
					end
				end
			endcase
		end
	end

	// Acquisition window: falling edges five through eight
	assign acq_active = (st_q != TADC_IDLE) && (fall_q >= 5'(TADC_ACQ_EDGE))
		&& (fall_q < 5'(TADC_ACQ_EDGE + TADC_ACQ_CYC));

	///////////////////////////////////////////////////////////////////////////
	// Sample held at end of acquisition, straight binary
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			code_q <= TADC_RES_RST;
		end else if (fall && acq_active && fall_q == 5'(TADC_ACQ_EDGE + TADC_ACQ_CYC - 1)) begin
			code_q <= sample_code;
		end
	end

	// Control word register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_word <= TADC_CTRL_RST;
		end else if (st_q == TADC_CMD && rise && bit_q == 5'(TADC_CTRL_BITS - 1)) begin
			ctrl_word <= {1'b1, cmd_q[5:0], din_sync_q[1]};
		end
	end

	///////////////////////////////////////////////////////////////////////////
	// Result shifter and pin drivers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			res_q           <= TADC_RES_RST;
			link.dout_o     <= 1'b0;
			link.dout_oe    <= 1'b0;
			link.busy_o     <= 1'b0;
			link.busy_oe    <= 1'b0;
			link.pen_touch_irq_oe <= 1'b0;
		end else begin
			link.dout_oe <= sel;
			link.busy_oe <= sel;
			link.pen_touch_irq_oe <= pen_sync_q[1];
			link.busy_o  <= (st_q == TADC_CONV) && (fall_q == 5'(TADC_CTRL_BITS));
			if (!sel) begin
				link.dout_o <= 1'b0;
			end else if (fall && st_q == TADC_CONV && fall_q == 5'(TADC_CTRL_BITS)) begin
				link.dout_o <= code_q[11];
				res_q       <= {code_q[10:0], 1'b0};
			end else if (fall && st_q == TADC_OUT) begin
				link.dout_o <= res_q[11];
				res_q       <= {res_q[10:0], 1'b0};
			end
		end
	end
endmodule : tadc_dev

// ==== design/tadc_host.sv ====
// Host end: makes the link clock, sends control, collects results
`timescale 1ns/100ps
module tadc_host
	import tadc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	tadc_if.host             link,
	input  wire logic [7:0]  cmd_data,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	output logic [19:0]      res_data,
	output logic             res_valid,
	input  wire logic        res_ready,
	output logic             pen_down
);
	logic [2:0]  div_q;
	logic [4:0]  clk_cnt_q;
	logic        run_q;
	logic [7:0]  tx_q;
	logic [7:0]  cmd_q;
	logic [11:0] rx_q;
	logic [1:0]  dout_sync_q;
	logic [1:0]  pen_sync_q;
	logic        push_q;
	logic        fifo_ready;
	logic        tick;

	assign tick = (div_q == 3'(TADC_CLK_DIV - 1));

	// Command acceptance, stalls on full result buffer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_ready <= 1'b0;
		end else begin
			// Push in flight still counts as a filled slot
			cmd_ready <= ~run_q & ~push_q & fifo_ready & ~(cmd_valid & cmd_ready);
		end
	end

	// Frame engine, clock divider and shifting
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q     <= 3'h0;
			clk_cnt_q <= 5'h00;
			run_q     <= 1'b0;
			tx_q      <= 8'h00;
			cmd_q     <= 8'h00;
			rx_q      <= 12'h000;
			push_q    <= 1'b0;
			link.cs_b <= 1'b1;
			link.serial_conversion_clock <= 1'b0;
			link.din  <= 1'b0;
		end else begin
			push_q <= 1'b0;
			if (!run_q) begin
				if (cmd_valid && cmd_ready) begin
					run_q     <= 1'b1;
					link.cs_b <= 1'b0;
					link.din  <= 1'b1;
					tx_q      <= {cmd_data[6:0], 1'b0};  // Start bit already on pin
					cmd_q     <= {1'b1, cmd_data[6:0]};
					clk_cnt_q <= 5'h00;
					div_q     <= 3'h0;
				end
			end else begin
				div_q <= tick ? 3'h0 : div_q + 3'h1;
				if (tick) begin
					if (!link.serial_conversion_clock) begin
						if (clk_cnt_q == 5'(TADC_CONV_CLKS)) begin
							run_q     <= 1'b0;
							link.cs_b <= 1'b1;
							push_q    <= 1'b1;
						end else begin
							link.serial_conversion_clock <= 1'b1;
						end
					end else begin
						link.serial_conversion_clock <= 1'b0;
						clk_cnt_q <= clk_cnt_q + 5'h01;
						link.din  <= tx_q[7];
						tx_q      <= {tx_q[6:0], 1'b0};
						// Sample result as the falling edge is driven, before the device shifts
						if (clk_cnt_q > 5'(TADC_CTRL_BITS) &&
							clk_cnt_q <= 5'(TADC_CTRL_BITS + TADC_RES_BITS)) begin
							rx_q <= {rx_q[10:0], dout_sync_q[1]};
						end
					end
				end
			end
		end
	end

	// Synchronisers for returned pins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dout_sync_q <= 2'h0;
			pen_sync_q  <= 2'h3;
			pen_down    <= 1'b0;
		end else begin
			dout_sync_q <= {dout_sync_q[0], link.dout_w};
			pen_sync_q  <= {pen_sync_q[0], link.pen_touch_irq_w};
			pen_down    <= ~pen_sync_q[1];
		end
	end

	tadc_fifo #(.WIDTH(TADC_FIFO_W), .DEPTH(TADC_FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_data   ({cmd_q, rx_q}),
		.in_valid  (push_q),
		.in_ready  (fifo_ready),
		.out_data  (res_data),
		.out_valid (res_valid),
		.out_ready (res_ready)
	);
endmodule : tadc_host

// ==== testbench/tadc_sva.sv ====
// Link protocol assertions for the touch converter
`timescale 1ns/100ps
module tadc_sva
	import tadc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic serial_conversion_clock,
	input wire logic din,
	input wire logic dout_o,
	input wire logic dout_oe,
	input wire logic busy_o,
	input wire logic busy_oe,
	input wire logic pen_touch_irq_oe
);
	logic       sclk_q;
	logic [3:0] since_q;
	logic [5:0] rise_q;
	logic [5:0] fall_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////
	// Link clock edge counters
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q <= 1'b0;
			since_q <= 4'hF;
			rise_q <= 6'h00;
			fall_q <= 6'h00;
		end else begin
			sclk_q <= serial_conversion_clock;
			since_q <= (sclk_q && !serial_conversion_clock) ? 4'h0
				: since_q + {3'h0, since_q != 4'hF};
			rise_q <= cs_b ? 6'h00 : rise_q + {5'h00, !sclk_q && serial_conversion_clock};
			fall_q <= cs_b ? 6'h00 : fall_q + {5'h00, sclk_q && !serial_conversion_clock};
		end
	end
	////////////////////////////////////////////////////////////////
	// Pin rules
	dout_rel_a: assert property (cs_b [*4] |-> !dout_oe)
		else $error("result pin driven while deselected");
	busy_rel_a: assert property (cs_b [*4] |-> !busy_oe)
		else $error("busy pin driven while deselected");
	sel_drive_a: assert property (!cs_b [*5] |-> dout_oe && busy_oe)
		else $error("selected end not driving its outputs");
	dout_fall_a: assert property (dout_oe && $past(dout_oe) && $changed(dout_o)
		|-> since_q <= 4'h5) else $error("result bit moved away from falling edge");
	din_stable_a: assert property ($rose(serial_conversion_clock) |-> $stable(din))
		else $error("control bit moved at rising edge");
	sclk_rate_a: assert property ($changed(serial_conversion_clock)
		|=> $stable(serial_conversion_clock) [*3]) else $error("link clock half period short");
	frame_len_a: assert property ($rose(cs_b) |-> rise_q == 6'(TADC_CONV_CLKS))
		else $error("frame clock count wrong");
	trail_zero_a: assert property (since_q == 4'h6 && fall_q >= 6'd21 && dout_oe
		|-> !dout_o) else $error("trailing bit not zero");
endmodule : tadc_sva

// ==== testbench/tadc_bench.sv ====
// Self-checking bench joining both link ends
`timescale 1ns/100ps
module tadc_bench
	import tadc_pkg::*;
;
	`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
		$display("BAD %0t got %h exp %h", $time, a, e); end end
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [11:0] code = 12'h000;
	logic        pen_in = 1'b0;
	logic [7:0]  cmd = 8'h00;
	logic        cmd_valid = 1'b0;
	logic        res_ready = 1'b0;
	logic        acq, cmd_ready, res_valid, pen_out;
	logic [7:0]  ctrl_word;
	logic [19:0] res_data;
	logic        sclk_q = 1'b0;
	logic        cs_q = 1'b1;
	logic [23:0] dout_cap, din_cap;
	int          fail_count = 0, samples_checked = 0;
	int          fall_n = 0, acq_n = 0, acq_at = 0, frames = 0;
	always #12.5 clk = ~clk;
	tadc_if tadc_if_i ();
	tadc_dev tadc_dev_i (.clk(clk), .rst_b(rst_b), .link(tadc_if_i.dev), .sample_code(code),
		.pen_down(pen_in), .acq_active(acq), .ctrl_word(ctrl_word));
	tadc_host tadc_host_i (.clk(clk), .rst_b(rst_b), .link(tadc_if_i.host), .cmd_data(cmd),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .res_data(res_data),
		.res_valid(res_valid), .res_ready(res_ready), .pen_down(pen_out));
	tadc_sva tadc_sva_i (.clk(clk), .rst_b(rst_b), .cs_b(tadc_if_i.cs_b),
		.serial_conversion_clock(tadc_if_i.serial_conversion_clock), .din(tadc_if_i.din),
		.dout_o(tadc_if_i.dout_o), .dout_oe(tadc_if_i.dout_oe), .busy_o(tadc_if_i.busy_o),
		.busy_oe(tadc_if_i.busy_oe), .pen_touch_irq_oe(tadc_if_i.pen_touch_irq_oe));
	////////////////////////////////////////////////////////////////
	// Wire monitor: bits at rising edges, falls, acquisition span
	always @(posedge clk) begin
		sclk_q <= tadc_if_i.serial_conversion_clock;
		cs_q <= tadc_if_i.cs_b;
		if (cs_q && !tadc_if_i.cs_b) begin
			fall_n <= 0;
			acq_n <= 0;
			frames <= frames + 1;
		end
		if (!sclk_q && tadc_if_i.serial_conversion_clock && !tadc_if_i.cs_b) begin
			dout_cap <= {dout_cap[22:0], tadc_if_i.dout_w};
			din_cap <= {din_cap[22:0], tadc_if_i.din};
		end
		if (sclk_q && !tadc_if_i.serial_conversion_clock)
			fall_n <= fall_n + 1;
		if (acq === 1'b1)
			acq_n <= acq_n + 1;
		if (acq === 1'b1 && acq_n == 0)
			acq_at <= fall_n;
	end
	////////////////////////////////////////////////////////////////
	// Offer one command, hold until taken
	task automatic send(input logic [7:0] c, input logic [11:0] v);
		@(posedge clk);
		cmd <= c;
		cmd_valid <= 1'b1;
		repeat (2000) if (cmd_ready !== 1'b1) @(negedge clk);
		`CHK(cmd_ready, 1'b1)
		@(posedge clk);
		cmd_valid <= 1'b0;
		code <= v;
	endtask : send
	// Take one result word and compare it
	task automatic recv(input logic [19:0] e);
		@(negedge clk);
		repeat (2000) if (res_valid !== 1'b1) @(negedge clk);
		`CHK(res_valid, 1'b1)
		`CHK(res_data, e)
		@(posedge clk);
		res_ready <= 1'b1;
		@(posedge clk);
		res_ready <= 1'b0;
	endtask : recv
	// One frame, judged on the wire and at both user sides
	task automatic t_single(input logic [7:0] c, input logic [11:0] v);
		send(c, v);
		recv({c | 8'h80, v});
		repeat (6) @(negedge clk);
		`CHK(dout_cap[15:0], {1'b0, v, 3'h0})
		`CHK(din_cap[23:16], c | 8'h80)
		`CHK(ctrl_word, c | 8'h80)
		`CHK(acq_at, TADC_ACQ_EDGE)
		`CHK(acq_n, TADC_ACQ_CYC * 2 * TADC_CLK_DIV)
		`CHK(tadc_if_i.dout_oe, 1'b0)
		`CHK(tadc_if_i.busy_oe, 1'b0)
		$display("test single %h done", v);
	endtask : t_single
	// Pen contact pulls the open-drain line
	task automatic t_pen();
		@(posedge clk);
		pen_in <= 1'b1;
		repeat (8) @(negedge clk);
		`CHK(tadc_if_i.pen_touch_irq_w, 1'b0)
		`CHK(pen_out, 1'b1)
		@(posedge clk);
		pen_in <= 1'b0;
		repeat (8) @(negedge clk);
		`CHK(tadc_if_i.pen_touch_irq_w, 1'b1)
		`CHK(pen_out, 1'b0)
		$display("test pen done");
	endtask : t_pen
	// Fill the result buffer with reader stalled, then drain
	task automatic t_fill();
		int f;
		for (int i = 0; i < TADC_FIFO_DEPTH; i++)
			send(8'h40 + 8'(i), 12'(i * 291));
		repeat (4) @(negedge clk);
		f = frames;
		@(posedge clk);
		cmd_valid <= 1'b1;
		repeat (600) @(negedge clk);
		`CHK(frames, f)
		`CHK(cmd_ready, 1'b0)
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (int i = 0; i < TADC_FIFO_DEPTH; i++)
			recv({8'hC0 + 8'(i), 12'(i * 291)});
		repeat (4) @(negedge clk);
		`CHK(res_valid, 1'b0)
		$display("test fill done");
	endtask : t_fill
	// Verdict and end of run
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		t_single(8'h13, 12'hA5C);
		t_single(8'h95, 12'h000);
		t_single(8'h7F, 12'hFFF);
		t_pen();
		t_fill();
		results();
	end
	// Watchdog: about five times the expected 35 frames
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		results();
	end
endmodule : tadc_bench
